/* File: rtl/smps_top.sv */
// Stop mode power sequencer: picks stop2 or stop3 on a stop instruction,
// holds pin latches, handles wake-up and the wake flag handshake.
// Assumes the CPU, wake sources and debug controller share REF_CLK; pins
// (reset pin, ext interrupt pin) are asynchronous and synchronised here.
//
// Notes on behaviour
// - Stop with enable set halts clocks.
// - Stop without enable forces illegal opcode reset.
// - Select bit one gives stop2, zero stop3.
// - Voltage detector enabled in stop forces stop3.
// - Debug enable turns stop2 attempt into stop3.
// - Debug enable keeps debug clocks, full regulation.
// - Voltage detector in stop keeps regulator active.
// - Stop2 powers off all but RAM.
// - Stop2 latches pins until acknowledge written.
// - Stop2 exits on reset, ext pin, timer.
// - Ext pin active low in stop2, no pullup.
// - Stop2 wake restarts as power-on reset.
// - Wake flag set until acknowledge written.
// - Opened latches follow port registers.
// - Unconfigured peripheral pins follow port control.
// - Stop3 keeps all state, RAM and pins.
// - Stop3 exits on reset or listed interrupts.
// - Reset exit vectors reset, interrupt to handler.
// - Status debug commands return stopped error.
// - Background command wakes into background mode.
`timescale 1ns/1ps
module smps_top
    import smps_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic STOP_INSN,
    input wire logic RESET_PIN_N,
    input wire logic EXT_INT_PIN_N,
    input wire logic TIMER_WAKE,
    input wire logic LVD_INT,
    input wire logic ADC_INT,
    input wire logic KBI_INT,
    input wire logic BKGD_CMD,
    input wire logic STATUS_CMD,
    output logic CLOCKS_HALT,
    output logic DEBUG_CLK_ON,
    output logic REG_STANDBY,
    output logic CORE_POWER_OFF,
    output logic PIN_LATCH_HOLD,
    output logic ILLEGAL_OP_RESET,
    output logic POR_RESTART,
    output logic TAKE_IRQ_VECTOR,
    output logic ENTER_BACKGROUND,
    output logic CMD_STOPPED_ERR,
    output logic EXT_PIN_ACTIVE_LOW
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_sync;
    logic [1:0] irq_sync;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync <= 2'h3;
            irq_sync <= 2'h3;
        end else begin
            rst_sync <= {rst_sync[0], RESET_PIN_N};
            irq_sync <= {irq_sync[0], EXT_INT_PIN_N};
        end
    end
    wire reset_pin_hit = !rst_sync[1];
    // Ext pin is read only as active low; its pullup is not touched here.
    wire irq_pin_hit = !irq_sync[1];

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    smps_ctl_t ctl;
    logic wake_flag;
    wire have_aw = !S_AXI_AWREADY;
    wire have_w = !S_AXI_WREADY;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    smps_state_t state;

    wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID && S_AXI_WREADY;
    wire wr_go = have_aw && have_w && !S_AXI_BVALID;
    wire wr_ctl = wr_go && (aw_addr == ADDR_CONTROL);
    wire wr_hit = wr_ctl || (wr_go && aw_addr == ADDR_STATUS);
    wire lane0 = w_strb[0];
    wire ack_pulse = wr_ctl && lane0 && w_data[CTL_PD_ACK];
    wire rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
    wire [31:0] ctl_word = {27'h0, ctl};
    wire [31:0] sta_word = {28'h0, PIN_LATCH_HOLD, state == SMPS_STOP3,
        state == SMPS_STOP2, wake_flag};
    wire rd_ctl = S_AXI_ARADDR == ADDR_CONTROL;
    wire rd_sta = S_AXI_ARADDR == ADDR_STATUS;

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                S_AXI_AWREADY <= 1'b0;
                aw_addr <= S_AXI_AWADDR;
            end
            if (w_take) begin
                S_AXI_WREADY <= 1'b0;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end
    // Ready flags are flops, so no bus output is combinational.

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (rd_take) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RDATA <= rd_ctl ? ctl_word : (rd_sta ? sta_word : 32'h0);
            S_AXI_RRESP <= (rd_ctl || rd_sta) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Mode selection and sequencing
    // ------------------------------------------------------------------
    // voltage detector override
    wire lvd_in_stop = ctl.lowvolt_detect_enable && ctl.lowvolt_detect_stop_enable;
    wire pick_stop2 = ctl.partial_power_down_select && !lvd_in_stop
        && !ctl.debug_mode_entry_enable;
    wire in_stop = state != SMPS_RUN;
    wire wake2 = reset_pin_hit || irq_pin_hit || TIMER_WAKE;
    wire int3 = TIMER_WAKE || LVD_INT || ADC_INT || irq_pin_hit || KBI_INT;
    wire bkgd_wake = BKGD_CMD && ctl.debug_mode_entry_enable;
    smps_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            SMPS_RUN: begin
                if (STOP_INSN && ctl.stop_enable) begin
                    next_state = pick_stop2 ? SMPS_STOP2 : SMPS_STOP3;
                end
            end
            SMPS_STOP2: begin
                if (wake2) begin
                    next_state = SMPS_RUN;
                end
            end
            SMPS_STOP3: begin
                if (reset_pin_hit || int3 || bkgd_wake) begin
                    next_state = SMPS_RUN;
                end
            end
            default: next_state = SMPS_RUN;
        endcase
    end
    wire leave2 = state == SMPS_STOP2 && wake2;
    wire leave3 = state == SMPS_STOP3 && next_state == SMPS_RUN;

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= SMPS_RUN;
            ctl <= CTL_RESET;
            wake_flag <= 1'b0;
            PIN_LATCH_HOLD <= 1'b0;
        end else begin
            state <= next_state;
            // any reset-type wake returns settings to defaults
            if (leave2 || (leave3 && reset_pin_hit)) begin
                ctl <= CTL_RESET;
            end else if (wr_ctl && lane0) begin
                ctl <= w_data[4:0];
            end
            // wake flag, set wins over acknowledge
            if (leave2) begin
                wake_flag <= 1'b1;
            end else if (ack_pulse) begin
                wake_flag <= 1'b0;
            end
            // pins held until acknowledge; then port logic rules
            if (state == SMPS_RUN && next_state == SMPS_STOP2) begin
                PIN_LATCH_HOLD <= 1'b1;
            end else if (ack_pulse && !leave2 && state == SMPS_RUN) begin
                PIN_LATCH_HOLD <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Power and event outputs
    // ------------------------------------------------------------------
    // Stop3 keeps state by leaving the core powered; clocks halt and the regulator goes to standby unless debug or the detector is on.
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            CLOCKS_HALT <= 1'b0;
            DEBUG_CLK_ON <= 1'b1;
            REG_STANDBY <= 1'b0;
            CORE_POWER_OFF <= 1'b0;
            ILLEGAL_OP_RESET <= 1'b0;
            POR_RESTART <= 1'b0;
            TAKE_IRQ_VECTOR <= 1'b0;
            ENTER_BACKGROUND <= 1'b0;
            CMD_STOPPED_ERR <= 1'b0;
            EXT_PIN_ACTIVE_LOW <= 1'b0;
        end else begin
            CLOCKS_HALT <= next_state != SMPS_RUN;
            DEBUG_CLK_ON <= next_state == SMPS_RUN || ctl.debug_mode_entry_enable;
            // regulator standby only without debug or detector
            REG_STANDBY <= next_state != SMPS_RUN && !ctl.debug_mode_entry_enable
                && !lvd_in_stop;
            CORE_POWER_OFF <= next_state == SMPS_STOP2;
            EXT_PIN_ACTIVE_LOW <= next_state == SMPS_STOP2;
            ILLEGAL_OP_RESET <= state == SMPS_RUN && STOP_INSN && !ctl.stop_enable;
            // reset vector on stop2 wake or stop3 reset pin
            POR_RESTART <= leave2 || (leave3 && reset_pin_hit);
            TAKE_IRQ_VECTOR <= leave3 && !reset_pin_hit && int3;
            ENTER_BACKGROUND <= leave3 && !reset_pin_hit && !int3 && bkgd_wake;
            CMD_STOPPED_ERR <= in_stop && STATUS_CMD;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_stop2_latch: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        state == SMPS_STOP2 |-> PIN_LATCH_HOLD)
        else $error("pins not latched in stop2");
    a_flag_hold: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        leave2 |=> wake_flag)
        else $error("wake flag not set after stop2");
    a_illegal_stop: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        state == SMPS_RUN && STOP_INSN && !ctl.stop_enable |=> ILLEGAL_OP_RESET
        && state == SMPS_RUN)
        else $error("illegal stop not reset");
    a_lvd_override: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        state == SMPS_RUN && STOP_INSN && ctl.stop_enable && lvd_in_stop
        |=> state == SMPS_STOP3 && !REG_STANDBY)
        else $error("detector override failed");
    a_dbg_override: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        state == SMPS_RUN && STOP_INSN && ctl.stop_enable
        && ctl.debug_mode_entry_enable |=> state == SMPS_STOP3 && DEBUG_CLK_ON)
        else $error("debug override failed");
    a_stop2_pick: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        state == SMPS_RUN && STOP_INSN && ctl.stop_enable && pick_stop2
        |=> state == SMPS_STOP2 && CORE_POWER_OFF)
        else $error("stop2 not entered");
    a_clk_halt: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        $rose(in_stop) |-> CLOCKS_HALT)
        else $error("clocks not halted");
    a_ack_release: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ack_pulse && state == SMPS_RUN && !leave2 |=> !wake_flag && !PIN_LATCH_HOLD)
        else $error("acknowledge did not release");
    a_stop2_stay: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        state == SMPS_STOP2 && !wake2 |=> state == SMPS_STOP2)
        else $error("stop2 left without a wake source");
    a_stop3_stay: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        state == SMPS_STOP3 && !reset_pin_hit && !int3 && !bkgd_wake |=> state == SMPS_STOP3)
        else $error("stop3 left without a wake source");
    a_stopped_err: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        in_stop && STATUS_CMD |=> CMD_STOPPED_ERR)
        else $error("status command not refused in stop");
    a_bkgd_entry: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        state == SMPS_STOP3 && bkgd_wake && !reset_pin_hit && !int3
        |=> ENTER_BACKGROUND && state == SMPS_RUN)
        else $error("background command did not wake");
    a_por_restart: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        leave2 |=> POR_RESTART && ctl == CTL_RESET)
        else $error("stop2 wake not a reset restart");
    a_pin_reset3: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        leave3 && reset_pin_hit |=> POR_RESTART && ctl == CTL_RESET)
        else $error("stop3 reset pin exit not a reset");
    a_irq_vector: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        leave3 && !reset_pin_hit && int3 |=> TAKE_IRQ_VECTOR && !POR_RESTART)
        else $error("stop3 interrupt exit not vectored");
    a_reg_active: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        lvd_in_stop |=> !REG_STANDBY)
        else $error("regulator in standby with detector on");
    a_dbg_clocks: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ctl.debug_mode_entry_enable |=> DEBUG_CLK_ON && !REG_STANDBY)
        else $error("debug clocks or regulation lost");
    a_stop2_power: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        state == SMPS_STOP2 |-> EXT_PIN_ACTIVE_LOW && CORE_POWER_OFF)
        else $error("stop2 power or pin mode wrong");
    a_latch_kept: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        PIN_LATCH_HOLD && !ack_pulse |=> PIN_LATCH_HOLD)
        else $error("pin latch opened without acknowledge");

endmodule : smps_top

/* File: rtl/smps_pkg.sv */
// Package for the stop mode power sequencer: register map, field positions,
// reset values and state encoding. Assumes a 32-bit AXI4-Lite register bus.
package smps_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    // Control register field positions.
    localparam int CTL_STOP_EN = 0;
    localparam int CTL_PPD_SEL = 1;
    localparam int CTL_LVD_EN = 2;
    localparam int CTL_LVD_STOP_EN = 3;
    localparam int CTL_DBG_EN = 4;
    localparam int CTL_PD_ACK = 5;
    localparam logic [4:0] CTL_RESET = 5'h00;

    // Status register field positions.
    localparam int STA_WAKE_FLAG = 0;
    localparam int STA_IN_STOP2 = 1;
    localparam int STA_IN_STOP3 = 2;
    localparam int STA_LATCHED = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // States and carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SMPS_RUN = 2'b00,
        SMPS_STOP2 = 2'b01,
        SMPS_STOP3 = 2'b10
    } smps_state_t;

    typedef struct packed {
        logic rtc;
        logic low_voltage_detector;
        logic adc;
        logic irq;
        logic keypad_interrupt;
    } smps_wake_t;

    // The first field is the top bit, so stop_enable lands on bit 0 as mapped.
    typedef struct packed {
        logic debug_mode_entry_enable;
        logic lowvolt_detect_stop_enable;
        logic lowvolt_detect_enable;
        logic partial_power_down_select;
        logic stop_enable;
    } smps_ctl_t;

endpackage : smps_pkg

/* File: verification/smps_partner.sv */
// Far-side model: CPU stop strobe, wake sources and debug controller.
// Assumes the bench posts one request word a cycle on the shared clock.
`timescale 1ns/1ps
module smps_partner
    import smps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [8:0] req,
    output logic stop_insn,
    output logic reset_pin_n,
    output logic ext_int_pin_n,
    output smps_wake_t wake,
    output logic bkgd_cmd,
    output logic status_cmd
);
    // ------------------------------------------------------------------
    // Request register
    // ------------------------------------------------------------------
    // pin active low
    // Both pins idle high, since reset loads them high and idle request bits invert to high.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {stop_insn, reset_pin_n, ext_int_pin_n, wake, bkgd_cmd, status_cmd} <= 10'h180;
        end else begin
            {stop_insn, reset_pin_n, ext_int_pin_n, wake, bkgd_cmd, status_cmd} <=
                {req[0], !req[1], !req[2], req[3], req[4], req[5], req[2], req[6], req[7], req[8]};
        end
    end
endmodule : smps_partner

/* File: verification/test_stop_mode_power_sequencer.sv */
// Self-checking bench for the stop mode power sequencer.
// Assumes one 100 MHz clock; the partner model drives the wake side.
`timescale 1ns/1ps
module test_stop_mode_power_sequencer
    import smps_pkg::*;
;
    logic REF_CLK = 1'b0;
    logic RSTN = 1'b1;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'hf;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic STOP_INSN, RESET_PIN_N, EXT_INT_PIN_N, BKGD_CMD, STATUS_CMD;
    logic CLOCKS_HALT, DEBUG_CLK_ON, REG_STANDBY, CORE_POWER_OFF, PIN_LATCH_HOLD;
    logic ILLEGAL_OP_RESET, POR_RESTART, TAKE_IRQ_VECTOR, ENTER_BACKGROUND;
    logic CMD_STOPPED_ERR, EXT_PIN_ACTIVE_LOW;
    smps_wake_t wk;
    wire logic TIMER_WAKE = wk.rtc;
    wire logic LVD_INT = wk.low_voltage_detector;
    wire logic ADC_INT = wk.adc;
    wire logic KBI_INT = wk.keypad_interrupt;
    logic [8:0] req = 9'h000;
    logic [4:0] seen = 5'h00;
    logic clr = 1'b0;
    int checks = 0;
    int failures = 0;

    always #5 REF_CLK = ~REF_CLK;

    smps_partner partner (.clk(REF_CLK), .rst_n(RSTN), .req(req), .stop_insn(STOP_INSN),
        .reset_pin_n(RESET_PIN_N), .ext_int_pin_n(EXT_INT_PIN_N), .wake(wk),
        .bkgd_cmd(BKGD_CMD), .status_cmd(STATUS_CMD));
    smps_top dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .S_AXI_AWADDR(S_AXI_AWADDR),
        .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
        .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
        .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
        .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
        .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
        .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
        .S_AXI_RREADY(S_AXI_RREADY), .STOP_INSN(STOP_INSN), .RESET_PIN_N(RESET_PIN_N),
        .EXT_INT_PIN_N(EXT_INT_PIN_N), .TIMER_WAKE(TIMER_WAKE), .LVD_INT(LVD_INT),
        .ADC_INT(ADC_INT), .KBI_INT(KBI_INT), .BKGD_CMD(BKGD_CMD), .STATUS_CMD(STATUS_CMD),
        .CLOCKS_HALT(CLOCKS_HALT), .DEBUG_CLK_ON(DEBUG_CLK_ON), .REG_STANDBY(REG_STANDBY),
        .CORE_POWER_OFF(CORE_POWER_OFF), .PIN_LATCH_HOLD(PIN_LATCH_HOLD),
        .ILLEGAL_OP_RESET(ILLEGAL_OP_RESET), .POR_RESTART(POR_RESTART),
        .TAKE_IRQ_VECTOR(TAKE_IRQ_VECTOR), .ENTER_BACKGROUND(ENTER_BACKGROUND),
        .CMD_STOPPED_ERR(CMD_STOPPED_ERR), .EXT_PIN_ACTIVE_LOW(EXT_PIN_ACTIVE_LOW));

    // One-cycle pulses are caught here so that no exact cycle has to be guessed.
    always @(posedge REF_CLK) seen <= clr ? 5'h00 : seen | {CMD_STOPPED_ERR,
        ENTER_BACKGROUND, TAKE_IRQ_VECTOR, POR_RESTART, ILLEGAL_OP_RESET};

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic lim(input int n);
        if (n >= 40) begin
            failures++;
            complete_run();
        end
    endtask : lim

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge REF_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        for (n = 0; n < 40 && (pa || pw || S_AXI_BVALID !== 1'b1); n++) begin
            @(posedge REF_CLK);
            if (pa && S_AXI_AWREADY === 1'b1) begin
                pa = 1'b0;
                S_AXI_AWVALID <= 1'b0;
            end
            if (pw && S_AXI_WREADY === 1'b1) begin
                pw = 1'b0;
                S_AXI_WVALID <= 1'b0;
            end
        end
        lim(n);
        S_AXI_BREADY <= 1'b0;
        chk(S_AXI_BRESP, RESP_OKAY);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic pa;
        pa = 1'b1;
        @(posedge REF_CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        for (n = 0; n < 40 && (pa || S_AXI_RVALID !== 1'b1); n++) begin
            @(posedge REF_CLK);
            if (pa && S_AXI_ARREADY === 1'b1) begin
                pa = 1'b0;
                S_AXI_ARVALID <= 1'b0;
            end
        end
        lim(n);
        S_AXI_RREADY <= 1'b0;
        chk(S_AXI_RDATA, ed);
        chk(S_AXI_RRESP, er);
    endtask : rd

    task automatic go(input logic [8:0] r, input int n);
        @(posedge REF_CLK);
        req <= r;
        clr <= 1'b1;
        @(posedge REF_CLK);
        clr <= 1'b0;
        repeat (n - 1) @(posedge REF_CLK);
        req <= 9'h000;
        repeat (6) @(posedge REF_CLK);
    endtask : go

    function automatic logic is_s2(input logic [3:0] c);
        return c[0] && !(c[1] && c[2]) && !c[3];
    endfunction : is_s2

    initial begin
        int i;
        logic [3:0] c;
        logic s2;
        logic [31:0] ctl;
        logic [8:0] w;
        RSTN = 1'b0;
        void'($urandom(32'h1b4aa52a));
        repeat (4) @(posedge REF_CLK);
        RSTN <= 1'b1;
        @(posedge REF_CLK);
        chk(DEBUG_CLK_ON, 1'b1);
        rd(ADDR_CONTROL, 32'h0, RESP_OKAY);
        rd(8'h0c, 32'h0, RESP_SLVERR);
        wr(ADDR_CONTROL, 32'h2);
        go(9'h001, 1);
        chk(seen[0], 1'b1);
        chk(CLOCKS_HALT, 1'b0);
        $display("illegal stop test done");
        for (i = 0; i < 24; i++) begin
            c = (i < 16) ? i[3:0] : 4'($urandom_range(15));
            ctl = {27'h0, c, 1'b1};
            s2 = is_s2(c);
            wr(ADDR_CONTROL, ctl);
            go(9'h001, 1);
            chk(CLOCKS_HALT, 1'b1);
            chk(CORE_POWER_OFF, s2);
            chk(EXT_PIN_ACTIVE_LOW, s2);
            chk(PIN_LATCH_HOLD, s2);
            chk(DEBUG_CLK_ON, c[3]);
            chk(REG_STANDBY, !(c[3] || (c[1] && c[2])));
            rd(ADDR_STATUS, {28'h0, s2, !s2, s2, 1'b0}, RESP_OKAY);
            go(9'h100, 1);
            chk(seen[4], 1'b1);
            if (s2) begin
                go(9'h070, 4);
                chk({CLOCKS_HALT, seen[2:1]}, 3'b100);
                go(9'h002 << $urandom_range(2), 4);
                chk(seen[1], 1'b1);
                rd(ADDR_STATUS, 32'h9, RESP_OKAY);
                rd(ADDR_CONTROL, 32'h0, RESP_OKAY);
                // Software puts its settings back before it opens the latches.
                wr(ADDR_CONTROL, ctl);
                rd(ADDR_STATUS, 32'h9, RESP_OKAY);
                wr(ADDR_CONTROL, ctl | 32'h20);
                rd(ADDR_STATUS, 32'h0, RESP_OKAY);
                rd(ADDR_CONTROL, ctl, RESP_OKAY);
                chk(PIN_LATCH_HOLD, 1'b0);
            end else begin
                w = (c[3] && i[0]) ? 9'h080 : 9'h002 << $urandom_range(5);
                go(w, 3);
                chk(CLOCKS_HALT, 1'b0);
                chk(seen[3:1], w[7] ? 3'b100 : (w[1] ? 3'b001 : 3'b010));
                rd(ADDR_CONTROL, w[1] ? 32'h0 : ctl, RESP_OKAY);
            end
            $display("stop test %0d done", i);
        end
        complete_run();
    end
endmodule : test_stop_mode_power_sequencer
